// file: core/fper_pkg.sv
// Package with constants and types for the floating-point exception resolver.
// Overview of operation
// - Flag potential underflow when unbounded-exponent rounded result is non-zero and below normal.
// - Tiny means magnitude below 2^-126, 2^-1022 or 2^-16382 per format.
// - Masked underflow sets the underflow flag only when tiny and inexact.
// - Masked underflow writes a signed result no larger than smallest normal.
// - Unmasked underflow reports any non-zero tiny result and requests the handler.
// - Raise inexact whenever the result is not exactly representable.
// - Masked inexact alone sets precision flag and stores the rounded result.
// - Unmasked inexact alone sets precision flag, stores rounded result, requests handler.
// - Inexact with masked overflow/underflow sets both flags; handler only if inexact unmasked.
// - Inexact with unmasked overflow/underflow to register sets both flags and requests handler.
// - Unmasked overflow/underflow on memory store hides inexact and clears round-up bit.
// - Fixed precedence from stack faults down to inexact among simultaneous conditions.
// - With all conditions masked the highest-priority one is handled; a masked denormal lets post-operation flags follow.
// - Quiet NaN operand wins over lower conditions, raising no divide-by-zero.
// - After masked denormal, execution continues and lower conditions may be flagged.
// - Denormal or inexact may be flagged together with overflow or underflow.
// - Invalid, divide-by-zero, denormal are pre-operation; the rest post-operation.
// - Unmasked pre-operation condition leaves the destination untouched.
// - Unmasked overflow or underflow never writes the packed unit destination.
// - Sticky flags sit at bits 0-5, masks at bits 7-12 of the control register.
package fper_pkg;

    // Register byte addresses on the bus.
    localparam logic [11:0] CSR_ADDR   = 12'h000;
    localparam logic [11:0] STAT_ADDR  = 12'h004;

    // Flag positions; the mask of each sits MASK_LSB above it.
    localparam int FLG_INV  = 0;
    localparam int FLG_DEN  = 1;
    localparam int FLG_ZDV  = 2;
    localparam int FLG_OVF  = 3;
    localparam int FLG_UNF  = 4;
    localparam int FLG_PRC  = 5;
    localparam int MASK_LSB = 7;
    localparam int STAT_SEL_LSB = 6;
    localparam int STAT_WR  = 9;
    localparam int STAT_HND = 10;

    // Reset values: all flags clear, all conditions masked.
    localparam logic [5:0] FLAGS_RESET = 6'h00;
    localparam logic [5:0] MASKS_RESET = 6'h3f;

    // Destination format codes.
    localparam logic [1:0] FMT_SINGLE = 2'h0;
    localparam logic [1:0] FMT_DOUBLE = 2'h1;

    // Smallest normal exponents: -126, -1022 and -16382.
    localparam logic signed [17:0] EMIN_SINGLE = -18'sh0007e;
    localparam logic signed [17:0] EMIN_DOUBLE = -18'sh003fe;
    localparam logic signed [17:0] EMIN_EXT    = -18'sh03ffe;

    // Which result the datapath must place in the destination.
    typedef enum logic [2:0] {
        SEL_ROUNDED,
        SEL_QNAN_DEF,
        SEL_QNAN_PROP,
        SEL_ZDIV_INF,
        SEL_OVF_MASKED,
        SEL_UNF_MASKED,
        SEL_BIASED
    } fper_sel_e;

    // Classification of one result from the datapath.
    typedef struct packed {
        logic              valid;
        logic              scalarUnit;
        logic              memDest;
        logic [1:0]        fmt;
        logic              resNonZero;
        logic signed [17:0] resExp;
        logic              stackUnder;
        logic              stackOver;
        logic              unsupported;
        logic              snan;
        logic              qnan;
        logic              otherInvalid;
        logic              divZero;
        logic              denormal;
        logic              overflow;
        logic              inexact;
        logic              roundUp;
    } fper_class_s;

    // Resolution answer toward datapath and pipeline.
    typedef struct packed {
        logic       valid;
        logic       writeDest;
        fper_sel_e  sel;
        logic       handlerReq;
        logic       roundUpBit;
        logic [5:0] flags;
    } fper_resp_s;

    // Whole state of the resolver.
    typedef struct packed {
        logic [5:0]  flags;
        logic [5:0]  masks;
        fper_resp_s  resp;
        logic [31:0] rdata;
    } fper_state_s;

endpackage

// file: core/fper_resolver.sv
// Floating-point exception resolver with its control-status register on APB.
`timescale 1ns/1ps

module fper_resolver (
    input  wire logic              core_clk,
    input  wire logic              nrst,
    input  wire fper_pkg::fper_class_s cls,
    output fper_pkg::fper_resp_s   resp,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr
);
    import fper_pkg::*;

    fper_state_s st;
    fper_state_s next_st;
    logic        tiny;
    logic        preInv;
    logic        cleanOp;
    logic        csrWr;
    logic [31:0] csrWord;
    logic [31:0] statWord;
    logic [31:0] laneMask;
    logic [31:0] csrNew;

    // Smallest normal exponent of the active destination format.
    function automatic logic signed [17:0] eminOf(input logic [1:0] fmt);
        if (fmt == FMT_SINGLE) begin
            return EMIN_SINGLE;
        end else if (fmt == FMT_DOUBLE) begin
            return EMIN_DOUBLE;
        end else begin
            return EMIN_EXT;
        end
    endfunction

    // Tiny test on the unbounded rounded result; for the stack unit the
    // datapath hands in the precision-control format as fmt.
    assign tiny = cls.resNonZero && (cls.resExp < eminOf(cls.fmt));

    // Invalid causes of the top priority class.
    assign preInv = cls.stackUnder
                  | cls.stackOver
                  | (cls.unsupported & cls.scalarUnit)
                  | cls.snan;

    // No pre-operation condition and no NaN: only post checks remain.
    assign cleanOp = !preInv && !cls.qnan && !cls.otherInvalid
                   && !cls.divZero && !cls.denormal;

    // Register images; reserved bits read as zero.
    assign csrWord  = {19'h00000, st.masks, 1'b0, st.flags};
    assign statWord = {21'h000000, st.resp.handlerReq, st.resp.writeDest,
                       st.resp.sel, st.resp.flags};
    assign laneMask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    assign csrNew   = (csrWord & ~laneMask) | (pwdata & laneMask);
    assign csrWr    = psel && penable && pwrite && (paddr == CSR_ADDR);

    // Zero-wait slave; an unmapped address answers with an error.
    assign pready  = 1'b1;
    assign pslverr = psel && penable
                   && (paddr != CSR_ADDR) && (paddr != STAT_ADDR);
    assign prdata  = st.rdata;
    assign resp    = st.resp;

    // Resolution of one classified result, plus register access.
    always_comb begin
        logic [5:0] ev;
        logic       wr;
        logic       ru;
        logic       ufEv;
        logic       postUnm;
        fper_sel_e  sel;
        ev      = 6'h00;
        wr      = 1'b0;
        ru      = cls.roundUp;
        ufEv    = 1'b0;
        postUnm = 1'b0;
        sel     = SEL_ROUNDED;
        next_st = st;
        if (cls.valid) begin
            // Pre-operation checks come first, in priority order.
            if (preInv) begin
                ev[FLG_INV] = 1'b1;
                wr  = st.masks[FLG_INV];
                sel = SEL_QNAN_DEF;
            end else if (cls.qnan) begin
                wr  = 1'b1;
                sel = SEL_QNAN_PROP;
            end else if (cls.otherInvalid) begin
                ev[FLG_INV] = 1'b1;
                wr  = st.masks[FLG_INV];
                sel = SEL_QNAN_DEF;
            end else if (cls.divZero) begin
                ev[FLG_ZDV] = 1'b1;
                wr  = st.masks[FLG_ZDV];
                sel = SEL_ZDIV_INF;
            end else if (cls.denormal && !st.masks[FLG_DEN]) begin
                ev[FLG_DEN] = 1'b1;
                wr  = 1'b0;
            end else begin
                // Masked denormal falls through to the post checks.
                ev[FLG_DEN] = cls.denormal;
                if (st.masks[FLG_UNF]) begin
                    ufEv = tiny && cls.inexact;
                end else begin
                    ufEv = tiny;
                end
                ev[FLG_OVF] = cls.overflow;
                ev[FLG_UNF] = ufEv && !cls.overflow;
                postUnm = (ev[FLG_OVF] && !st.masks[FLG_OVF])
                        || (ev[FLG_UNF] && !st.masks[FLG_UNF]);
                if (postUnm) begin
                    // A store to memory hides the inexact report.
                    if (cls.memDest) begin
                        ev[FLG_PRC] = 1'b0;
                        ru = 1'b0;
                    end else begin
                        ev[FLG_PRC] = cls.inexact;
                    end
                    // Packed unit keeps its destination; stack unit stores biased to a register, not to memory.
                    wr  = cls.scalarUnit && !cls.memDest;
                    sel = SEL_BIASED;
                end else if (ev[FLG_OVF] || ev[FLG_UNF]) begin
                    ev[FLG_PRC] = cls.inexact;
                    wr  = 1'b1;
                    sel = ev[FLG_OVF] ? SEL_OVF_MASKED : SEL_UNF_MASKED;
                end else begin
                    ev[FLG_PRC] = cls.inexact;
                    wr  = 1'b1;
                    sel = SEL_ROUNDED;
                end
            end
        end
        // Sticky flags: a new event beats a software clear in the same cycle.
        if (csrWr) begin
            next_st.flags = csrNew[5:0] | ev;
            next_st.masks = csrNew[MASK_LSB +: 6];
        end else begin
            next_st.flags = st.flags | ev;
        end
        next_st.resp.valid      = cls.valid;
        next_st.resp.writeDest  = cls.valid && wr;
        next_st.resp.sel        = sel;
        next_st.resp.handlerReq = |(ev & ~st.masks);
        next_st.resp.roundUpBit = ru;
        next_st.resp.flags      = ev;
        // Read data is captured in the setup cycle, ready for the access phase.
        if (psel && !penable) begin
            if (paddr == CSR_ADDR) begin
                next_st.rdata = csrWord;
            end else if (paddr == STAT_ADDR) begin
                next_st.rdata = statWord;
            end else begin
                next_st.rdata = 32'h00000000;
            end
        end
    end

    // Single state register.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            st       <= '0;
            st.flags <= FLAGS_RESET;
            st.masks <= MASKS_RESET;
        end else begin
            st <= next_st;
        end
    end

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    // An answer always follows a classified result one cycle later.
    sequence s_answer;
        ##1 resp.valid;
    endsequence

    property p_uf_masked;
        cls.valid && cleanOp && tiny && !cls.inexact && !cls.overflow
            && st.masks[FLG_UNF] |-> s_answer ##0 !resp.flags[FLG_UNF];
    endproperty
    a_uf_masked: assert property (p_uf_masked) else $error("Exact tiny result flagged underflow.");

    property p_uf_unmasked;
        cls.valid && cleanOp && tiny && !cls.overflow && !st.masks[FLG_UNF]
            |-> s_answer ##0 (resp.flags[FLG_UNF] && resp.handlerReq);
    endproperty
    a_uf_unmasked: assert property (p_uf_unmasked) else $error("Unmasked tiny result not reported.");

    property p_simd_keep;
        cls.valid && cleanOp && !cls.scalarUnit && cls.overflow && !st.masks[FLG_OVF]
            |-> s_answer ##0 !resp.writeDest;
    endproperty
    a_simd_keep: assert property (p_simd_keep) else $error("Packed unit destination written.");

    property p_snan_zdiv;
        cls.valid && cls.snan && cls.divZero
            |-> s_answer ##0 (resp.flags == 6'h01 && resp.sel == SEL_QNAN_DEF);
    endproperty
    a_snan_zdiv: assert property (p_snan_zdiv) else $error("Lower condition not suppressed.");

    property p_qnan;
        cls.valid && !preInv && cls.qnan
            |-> s_answer ##0 (resp.flags == 6'h00 && resp.sel == SEL_QNAN_PROP);
    endproperty
    a_qnan: assert property (p_qnan) else $error("Quiet NaN did not win.");

    // Only one cycle is promised: a software clear may follow right after.
    property p_sticky;
        st.flags[FLG_PRC] && !csrWr |=> st.flags[FLG_PRC];
    endproperty
    a_sticky: assert property (p_sticky) else $error("Sticky flag dropped by itself.");

    property p_mem_store;
        cls.valid && cleanOp && cls.memDest && cls.overflow && !st.masks[FLG_OVF]
            |-> s_answer ##0 (!resp.flags[FLG_PRC] && !resp.roundUpBit);
    endproperty
    a_mem_store: assert property (p_mem_store) else $error("Inexact reported on faulting store.");

    property p_pre_keep;
        cls.valid && !preInv && !cls.qnan && cls.divZero && !st.masks[FLG_ZDV]
            |-> s_answer ##0 (!resp.writeDest && resp.handlerReq);
    endproperty
    a_pre_keep: assert property (p_pre_keep) else $error("Pre-operation fault wrote destination.");

    property p_inexact_masked;
        cls.valid && cleanOp && cls.inexact && !cls.overflow && !tiny && &st.masks
            |-> s_answer ##0 (resp.flags == 6'h20 && resp.writeDest && !resp.handlerReq);
    endproperty
    a_inexact_masked: assert property (p_inexact_masked) else $error("Masked inexact mishandled.");

    property p_handler_cause;
        resp.handlerReq |-> resp.valid && (resp.flags != 6'h00);
    endproperty
    a_handler_cause: assert property (p_handler_cause) else $error("Handler request without flag.");

    // Masked overflow writes the masked overflow value.
    property p_ovf_masked;
        cls.valid && cleanOp && cls.overflow && st.masks[FLG_OVF]
            |-> s_answer ##0 (resp.flags[FLG_OVF] && resp.writeDest && resp.sel == SEL_OVF_MASKED);
    endproperty
    a_ovf_masked: assert property (p_ovf_masked) else $error("Masked overflow mishandled.");

    // Masked tiny and inexact result sets both flags and writes the small result.
    property p_uf_masked_set;
        cls.valid && cleanOp && tiny && cls.inexact && !cls.overflow && st.masks[FLG_UNF]
            |-> s_answer ##0 (resp.flags[FLG_UNF] && resp.flags[FLG_PRC]
                              && resp.writeDest && resp.sel == SEL_UNF_MASKED);
    endproperty
    a_uf_masked_set: assert property (p_uf_masked_set) else $error("Masked underflow mishandled.");

    // Unmasked inexact alone still writes the rounded result.
    property p_inexact_unmasked;
        cls.valid && cleanOp && cls.inexact && !cls.overflow && !tiny && !st.masks[FLG_PRC]
            |-> s_answer ##0 (resp.flags[FLG_PRC] && resp.writeDest && resp.handlerReq
                              && resp.sel == SEL_ROUNDED);
    endproperty
    a_inexact_unmasked: assert property (p_inexact_unmasked) else $error("Unmasked inexact mishandled.");

    // Unmasked overflow to a register keeps the precision report.
    property p_reg_dest;
        cls.valid && cleanOp && cls.overflow && !st.masks[FLG_OVF] && !cls.memDest && cls.inexact
            |-> s_answer ##0 (resp.flags[FLG_OVF] && resp.flags[FLG_PRC] && resp.handlerReq);
    endproperty
    a_reg_dest: assert property (p_reg_dest) else $error("Register overflow lost a flag.");

    // A masked denormal lets the post checks run as well.
    property p_den_continue;
        cls.valid && cls.denormal && st.masks[FLG_DEN] && !preInv && !cls.qnan
            && !cls.otherInvalid && !cls.divZero && cls.overflow
            |-> s_answer ##0 (resp.flags[FLG_DEN] && resp.flags[FLG_OVF]);
    endproperty
    a_den_continue: assert property (p_den_continue) else $error("Masked denormal stopped early.");

    // An unmasked denormal stops before the operation and keeps the destination.
    property p_den_unmasked;
        cls.valid && cls.denormal && !st.masks[FLG_DEN] && !preInv && !cls.qnan
            && !cls.otherInvalid && !cls.divZero
            |-> s_answer ##0 (resp.flags == 6'h02 && !resp.writeDest && resp.handlerReq);
    endproperty
    a_den_unmasked: assert property (p_den_unmasked) else $error("Unmasked denormal mishandled.");

    // A top-priority invalid lands in the sticky register.
    property p_flag_set;
        cls.valid && preInv |=> st.flags[FLG_INV];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("Invalid flag not made sticky.");

    // No classified result means no answer and no request.
    property p_resp_idle;
        !cls.valid |=> (!resp.valid && !resp.writeDest && !resp.handlerReq);
    endproperty
    a_resp_idle: assert property (p_resp_idle) else $error("Answer without a result.");

    // One step below the single-format threshold is tiny.
    property p_tiny_single;
        cls.valid && cleanOp && cls.fmt == FMT_SINGLE && cls.resNonZero
            && cls.resExp == EMIN_SINGLE - 18'sh00001 && !cls.overflow && !st.masks[FLG_UNF]
            |-> s_answer ##0 resp.flags[FLG_UNF];
    endproperty
    a_tiny_single: assert property (p_tiny_single) else $error("Single tiny threshold missed.");

    // A zero result is never tiny.
    property p_zero_not_tiny;
        cls.valid && cleanOp && !cls.resNonZero |-> s_answer ##0 !resp.flags[FLG_UNF];
    endproperty
    a_zero_not_tiny: assert property (p_zero_not_tiny) else $error("Zero result flagged underflow.");

endmodule

// file: testbench/fper_datapath_model.sv
// Stand-in for the datapath and pipeline that feed the resolver and collect its answers.
`timescale 1ns/1ps

module fper_datapath_model (
    input  wire logic                  core_clk,
    input  wire logic                  nrst,
    input  wire logic                  go,
    input  wire fper_pkg::fper_class_s nextCls,
    output fper_pkg::fper_class_s      cls,
    input  wire fper_pkg::fper_resp_s  resp,
    output fper_pkg::fper_resp_s       lastResp,
    output logic [15:0]                respCount
);
    import fper_pkg::*;

    // One result per request; idle cycles carry inverted junk so stale fields cannot pass for real ones.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            cls <= '0;
        end else begin
            cls       <= go ? nextCls : ~nextCls;
            cls.valid <= go;
        end
    end

    // The answer is a one-cycle pulse, so it is kept here for the bench to judge later.
    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            lastResp  <= '0;
            respCount <= '0;
        end else if (resp.valid) begin
            lastResp  <= resp;
            respCount <= respCount + 16'h1;
        end
    end
endmodule

// file: testbench/fp_exception_resolver_bench.sv
// Self-checking bench for the resolver: random and corner classifications plus register access.
`timescale 1ns/1ps

`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_total++; \
    $display("[FAIL] %0t got %h exp %h", $time, a, b); end end

module fp_exception_resolver_bench;
    import fper_pkg::*;

    logic        core_clk, nrst, go, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [15:0] respCount;
    logic [5:0]  masks, acc;
    logic [7:0]  lastE;
    fper_class_s nextCls, cls, c;
    fper_resp_s  resp, lastResp;
    int          err_total, comparisons, i;

    fper_resolver fper_resolver_inst (.core_clk(core_clk), .nrst(nrst), .cls(cls), .resp(resp), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    fper_datapath_model fper_datapath_model_inst (.core_clk(core_clk), .nrst(nrst), .go(go), .nextCls(nextCls),
        .cls(cls), .resp(resp), .lastResp(lastResp), .respCount(respCount));

    // Free-running 50 ns core clock.
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // One APB transfer; the request stands until pready is seen high, the wait is bounded.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        int k;
        @(posedge core_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge core_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge core_clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (k == 16) begin
            err_total++;
            end_sim();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // New masks also clear the sticky flags, as the handler would.
    task automatic set_masks(input logic [5:0] m);
        apb(1'b1, CSR_ADDR, {19'h0, m, 7'h00}, 4'hf);
        masks = m;
        acc = '0;
    endtask

    function automatic logic signed [17:0] emin(input logic [1:0] f);
        return (f == FMT_SINGLE) ? EMIN_SINGLE : (f == FMT_DOUBLE) ? EMIN_DOUBLE : EMIN_EXT;
    endfunction

    // Expected {writeDest, handlerReq, flags} after priority resolution.
    function automatic logic [7:0] predict(input fper_class_s x, input logic [5:0] m);
        logic [5:0] f;
        logic       pu;
        if (x.stackUnder | x.stackOver | (x.unsupported & x.scalarUnit) | x.snan)
            return {m[0], ~m[0], 6'h01};
        if (x.qnan)
            return 8'h80;
        f = x.otherInvalid ? 6'h01 : {3'h0, x.divZero, 2'h0};
        if (|f)
            return {~|(f & ~m), |(f & ~m), f};
        f = {4'h0, x.denormal, 1'b0};
        if (x.denormal & ~m[1])
            return 8'h42;
        f[3] = x.overflow;
        f[4] = ~x.overflow & x.resNonZero & (x.resExp < emin(x.fmt)) & (x.inexact | ~m[4]);
        pu = |(f[4:3] & ~m[4:3]);
        f[5] = x.inexact & ~(pu & x.memDest);
        return {~pu | (x.scalarUnit & ~x.memDest), |(f & ~m), f};
    endfunction

    // Random result with at most one invalid, NaN or divide-by-zero cause, none in 9 of 16 draws; denormal is drawn apart.
    function automatic fper_class_s rnd_class(input logic [31:0] r);
        fper_class_s x;
        x = '0;
        x.valid = 1'b1;
        x.scalarUnit = r[0];
        x.memDest = r[0] & r[1];
        x.fmt = r[3:2];
        x.resNonZero = r[4];
        x.resExp = emin(r[3:2]) + 18'(r[7:5]) - 18'h4;
        {x.stackUnder, x.stackOver, x.unsupported, x.snan, x.qnan, x.otherInvalid, x.divZero} =
            r[11] ? 7'h00 : 7'h01 << r[10:8];
        x.denormal = &r[13:12];
        x.overflow = &r[15:14];
        x.inexact = r[16];
        x.roundUp = r[17];
        return x;
    endfunction

    // Issue one result through the datapath model and judge the answer it collected.
    task automatic op(input fper_class_s x);
        logic [15:0] n;
        int          k;
        n = respCount;
        lastE = predict(x, masks);
        @(posedge core_clk);
        go      <= 1'b1;
        nextCls <= x;
        @(posedge core_clk);
        go <= 1'b0;
        k = 0;
        do begin
            @(negedge core_clk);
            k++;
        end while (respCount === n && k < 8);
        if (respCount === n) begin
            err_total++;
            end_sim();
        end
        `CHK(lastResp.flags, lastE[5:0])
        `CHK(lastResp.handlerReq, lastE[6])
        `CHK(lastResp.writeDest, lastE[7])
        acc |= lastE[5:0];
    endtask

    // Reset, corner cases, a random run, then the sticky flags and status.
    initial begin
        err_total = 0;
        comparisons = 0;
        {nrst, go, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        nextCls = '0;
        masks = 6'h3f;
        acc = '0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        void'($urandom(73));
        apb(1'b0, CSR_ADDR, 32'h0, 4'hf);
        `CHK(rd, 32'h00001f80)
        apb(1'b0, 12'h010, 32'h0, 4'hf);
        `CHK({er, rd}, 33'h100000000)
        for (i = 0; i < 6; i++) begin
            set_masks(i[0] ? 6'h2f : 6'h3f);
            c = '0;
            c.valid = 1'b1;
            c.resNonZero = 1'b1;
            c.fmt = 2'(i / 2);
            c.resExp = emin(c.fmt);
            op(c);
            c.resExp = emin(c.fmt) - 18'h1;
            op(c);
        end
        set_masks(6'h37);
        c = '0;
        {c.valid, c.scalarUnit, c.memDest, c.overflow, c.inexact, c.roundUp} = 6'h3f;
        op(c);
        `CHK(lastResp.roundUpBit, 1'b0)
        set_masks(6'h3f);
        c = '0;
        {c.valid, c.snan, c.divZero} = 3'h7;
        op(c);
        `CHK(lastResp.sel, SEL_QNAN_DEF)
        {c.snan, c.qnan} = 2'h1;
        op(c);
        `CHK(lastResp.sel, SEL_QNAN_PROP)
        for (i = 0; i < 240; i++) begin
            if (i % 30 == 0) set_masks(6'($urandom));
            op(rnd_class($urandom));
        end
        apb(1'b0, CSR_ADDR, 32'h0, 4'hf);
        `CHK(rd, {19'h0, masks, 1'b0, acc})
        apb(1'b1, CSR_ADDR, 32'h0, 4'h2);
        apb(1'b0, CSR_ADDR, 32'h0, 4'hf);
        `CHK(rd, {24'h0, masks[0], 1'b0, acc})
        apb(1'b0, STAT_ADDR, 32'h0, 4'hf);
        // The status image follows the answer pulse, so with no result in flight it reads idle.
        `CHK({rd[10:9], rd[5:0]}, 8'h00)
        end_sim();
    end
endmodule
